// ### shared/gw_pkg.sv
// constants of the gauge host word port
package gw_pkg;
    localparam logic [7:0]  ADDR_WR        = 8'h16;
    localparam logic [7:0]  ADDR_RD        = 8'h17;
    localparam logic [7:0]  OFS_TTE        = 8'h03;
    localparam logic [7:0]  OFS_TTF        = 8'h05;
    localparam logic [7:0]  OFS_PCT        = 8'h0d;
    localparam logic [7:0]  OFS_FLAGS      = 8'h19;
    localparam logic [7:0]  OFS_INST       = 8'h33;
    localparam logic [7:0]  OFS_MEAN       = 8'h34;
    localparam logic [7:0]  CRC_POLY       = 8'h07;
    localparam logic [7:0]  CRC_INIT       = 8'h00;
    localparam logic [15:0] FLAGS_RST      = 16'h0080;
    localparam logic [15:0] FLAGS_WR_MASK  = 16'hffbf;
    localparam int          RST_DET_BIT    = 7;
    localparam int          DISCH_BIT      = 6;
    localparam int          OVC_BIT        = 13;
    localparam int          OVD_BIT        = 10;
    localparam logic [15:0] NO_REP_DATA    = 16'hffff;
    localparam logic [15:0] UNMAPPED_DATA  = 16'h0000;
    localparam logic [6:0]  PCT_STEP       = 7'h0a;
    localparam logic [6:0]  PCT_FULL       = 7'h64;
    localparam logic [6:0]  CV_PCT         = 7'h50;
    localparam logic [15:0] CV_STEP        = 16'h0001;
    localparam int          AVG_SH         = 4;
    localparam logic signed [15:0] OVC_THR = 16'sh7000;
    localparam logic signed [15:0] OVD_THR = -16'sh7000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_CMD  = 3'b010,
        ST_WLO  = 3'b011,
        ST_WHI  = 3'b100,
        ST_WCRC = 3'b101,
        ST_TX   = 3'b110,
        ST_WAIT = 3'b111
    } gw_state_t;
endpackage : gw_pkg

// ### verilog/gw_word_port.sv
// gauge host word port: i2c slave, registers and time estimates
// What this block does
// R1: power-on reset sets the reset-detected flag, bit 7 of battery flags.
// R2: host clears the flag after start-up; reading 1 later means a reset.
// R3: time_until_empty reports remaining time until charge reaches zero.
// R4: learn time per 10% discharge drop, estimate from that rate.
// R5: while charging, keep the discharge rate learned before.
// R6: time_until_full reports total time to 100% over both charge phases.
// R7: in constant-current charging learn the rise rate for the estimate.
// R8: in constant-voltage charging each further 1% takes longer.
// R9: current registers hold signed microvolts, positive charging.
// R10: instant current holds the latest sample, used for current alarms.
// R11: mean current holds a smoothed average of samples.
// R12: host reads: address write, command, repeated start, read, nack crc.
// R13: answer address 0x16 for write and 0x17 for read, ack bytes.
// R14: read word goes low byte, high byte, then check byte.
// R15: check byte covers every byte from first address to last data.
// R16: a read with no repeated start after the command returns all ones.
// R17: word write is address, command, low, high, crc, all acked, stop.
// R18: crc-8 poly 0x07, init zero, no reflection, msb first.
// R19: a word write with a wrong crc is dropped.
module gw_word_port
    import gw_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic        ce_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output wire logic        sda_o,
    output wire logic        sda_oe_o,
    input  wire logic [6:0]  pct_i,
    input  wire logic        chg_i,
    input  wire logic        cv_i,
    input  wire logic        min_tick_i,
    input  wire logic [15:0] cur_sample_i,
    input  wire logic        cur_valid_i,
    output wire logic        reset_detected_o
);
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[7] ^ d[i]) ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0}; // R18
        end
        return r;
    endfunction : crc8

    function automatic logic [15:0] sat16(input logic [31:0] v);
        return (|v[31:16]) ? 16'hffff : v[15:0];
    endfunction : sat16

    // taper: k-th percent from the end costs rate plus k steps
    function automatic logic [31:0] cv_time(input logic [6:0] rem, input logic [15:0] rate);
        return 32'(rem) * 32'(rate) + 32'(CV_STEP) * ((32'(rem) * (32'(rem) + 32'd1)) >> 1);
    endfunction : cv_time

    // pin synchronisers; edges read stages two and three only
    logic [2:0] scl_s_r;
    logic [2:0] sda_s_r;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
        end else if (ce_i) begin
            scl_s_r <= {scl_s_r[1:0], scl_i};
            sda_s_r <= {sda_s_r[1:0], sda_i};
        end
    end
    logic scl_rise, scl_fall, bus_start, bus_stop, sda_in;
    assign sda_in    = sda_s_r[1];
    assign scl_rise  = ce_i & scl_s_r[1] & ~scl_s_r[2];
    assign scl_fall  = ce_i & ~scl_s_r[1] & scl_s_r[2];
    assign bus_start = ce_i & scl_s_r[1] & scl_s_r[2] & ~sda_s_r[1] & sda_s_r[2];
    assign bus_stop  = ce_i & scl_s_r[1] & scl_s_r[2] & sda_s_r[1] & ~sda_s_r[2];

    // gauge state
    logic [6:0]  pct_r, pct_nxt, ref_r, ref_nxt;
    logic [15:0] tmr_r, tmr_nxt, rate_dn_r, rate_dn_nxt, rate_up_r, rate_up_nxt;
    logic [15:0] tte_r, tte_nxt, ttf_r, ttf_nxt, inst_r, inst_nxt, mean_r, mean_nxt;
    logic [15:0] flags_r, flags_nxt;
    logic        dis_r, dis_nxt, chg_r, chg_nxt;
    // link state
    gw_state_t   st_r, st_nxt, nst_r, nst_nxt;
    logic [3:0]  bit_r, bit_nxt;
    logic [7:0]  sh_r, sh_nxt, cmd_r, cmd_nxt, crc_r, crc_nxt, tx_r, tx_nxt;
    logic [15:0] data_r, data_nxt;
    logic [1:0]  txi_r, txi_nxt;
    logic        oe_r, oe_nxt, rep_r, rep_nxt, nack_r, nack_nxt, wr_go;

    logic [15:0] rd_word;
    always_comb begin
        if (cmd_r == OFS_TTE) begin
            rd_word = tte_r;
        end else if (cmd_r == OFS_TTF) begin
            rd_word = ttf_r;
        end else if (cmd_r == OFS_PCT) begin
            rd_word = {9'h000, pct_r};
        end else if (cmd_r == OFS_FLAGS) begin
            rd_word = flags_r | (16'(dis_r) << DISCH_BIT);
        end else if (cmd_r == OFS_INST) begin
            rd_word = inst_r;
        end else if (cmd_r == OFS_MEAN) begin
            rd_word = mean_r;
        end else begin
            rd_word = UNMAPPED_DATA;
        end
    end

    always_comb begin
        logic [7:0] c;
        c        = crc8(crc_r, sh_r);
        st_nxt   = st_r;
        nst_nxt  = nst_r;
        bit_nxt  = bit_r;
        sh_nxt   = sh_r;
        cmd_nxt  = cmd_r;
        crc_nxt  = crc_r;
        tx_nxt   = tx_r;
        data_nxt = data_r;
        txi_nxt  = txi_r;
        oe_nxt   = oe_r;
        rep_nxt  = rep_r;
        nack_nxt = nack_r;
        wr_go    = 1'b0;
        if (bus_start) begin
            // park in an ack slot so the start's own scl fall is not counted as a bit
            st_nxt  = ST_ADDR;
            nst_nxt = ST_ADDR;
            bit_nxt = 4'h8;
            oe_nxt  = 1'b0;
            rep_nxt = (st_r == ST_WLO) && (bit_r == 4'h0);            // R16
            crc_nxt = rep_nxt ? crc_r : CRC_INIT;                      // R15
        end else if (bus_stop) begin
            st_nxt  = ST_IDLE;
            oe_nxt  = 1'b0;
            rep_nxt = 1'b0;
        end else if (scl_rise) begin
            if (st_r == ST_TX) begin
                if (bit_r == 4'h8) nack_nxt = sda_in;
            end else if (bit_r < 4'h8) begin
                sh_nxt = {sh_r[6:0], sda_in};
            end
        end else if (scl_fall && st_r != ST_IDLE && st_r != ST_WAIT) begin
            if (st_r == ST_TX) begin
                if (bit_r < 4'h7) begin
                    bit_nxt = bit_r + 4'h1;
                    oe_nxt  = ~tx_r[3'(3'd6 - bit_r[2:0])];
                end else if (bit_r == 4'h7) begin
                    bit_nxt = 4'h8;
                    oe_nxt  = 1'b0;
                end else if (nack_r || txi_r == 2'd2) begin
                    st_nxt = ST_WAIT;                                  // R12
                    oe_nxt = 1'b0;
                end else begin
                    c       = crc8(crc_r, tx_r);
                    crc_nxt = c;                                       // R15
                    tx_nxt  = (txi_r == 2'd0) ? data_r[15:8] : c;      // R14
                    txi_nxt = txi_r + 2'd1;
                    bit_nxt = 4'h0;
                    oe_nxt  = ~tx_nxt[7];
                end
            end else if (bit_r < 4'h7) begin
                bit_nxt = bit_r + 4'h1;
            end else if (bit_r == 4'h8) begin
                bit_nxt = 4'h0;
                st_nxt  = nst_r;
                oe_nxt  = (nst_r == ST_TX) ? ~tx_r[7] : 1'b0;
            end else begin
                bit_nxt = 4'h8;
                oe_nxt  = 1'b1;
                nst_nxt = ST_WAIT;
                crc_nxt = c;
                case (st_r)
                    ST_ADDR: begin
                        if (sh_r == ADDR_WR) begin
                            nst_nxt = ST_CMD;                          // R13
                        end else if (sh_r == ADDR_RD) begin
                            nst_nxt  = ST_TX;                          // R13
                            data_nxt = rep_r ? rd_word : NO_REP_DATA;  // R16
                            tx_nxt   = data_nxt[7:0];                  // R14
                            txi_nxt  = 2'd0;
                            nack_nxt = 1'b0;
                        end else begin
                            oe_nxt  = 1'b0;
                            crc_nxt = crc_r;
                        end
                    end
                    ST_CMD: begin
                        cmd_nxt = sh_r;
                        nst_nxt = ST_WLO;
                    end
                    ST_WLO: begin
                        data_nxt[7:0] = sh_r;                          // R17
                        nst_nxt       = ST_WHI;
                    end
                    ST_WHI: begin
                        data_nxt[15:8] = sh_r;
                        nst_nxt        = ST_WCRC;
                    end
                    default: begin
                        wr_go = (sh_r == crc_r);                       // R19
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r   <= ST_IDLE;
            nst_r  <= ST_IDLE;
            bit_r  <= 4'h0;
            sh_r   <= 8'h00;
            cmd_r  <= 8'h00;
            crc_r  <= CRC_INIT;
            tx_r   <= 8'h00;
            data_r <= 16'h0000;
            txi_r  <= 2'd0;
            oe_r   <= 1'b0;
            rep_r  <= 1'b0;
            nack_r <= 1'b0;
        end else if (ce_i) begin
            st_r   <= st_nxt;
            nst_r  <= nst_nxt;
            bit_r  <= bit_nxt;
            sh_r   <= sh_nxt;
            cmd_r  <= cmd_nxt;
            crc_r  <= crc_nxt;
            tx_r   <= tx_nxt;
            data_r <= data_nxt;
            txi_r  <= txi_nxt;
            oe_r   <= oe_nxt;
            rep_r  <= rep_nxt;
            nack_r <= nack_nxt;
        end
    end

    // open drain: only ever pulls low
    assign sda_o            = 1'b0;
    assign sda_oe_o         = oe_r;
    assign reset_detected_o = flags_r[RST_DET_BIT];

    always_comb begin
        logic signed [16:0] diff;
        diff        = 17'($signed(cur_sample_i)) - 17'($signed(mean_r));
        pct_nxt     = pct_i;
        chg_nxt     = chg_i;
        dis_nxt     = ~chg_i;
        ref_nxt     = ref_r;
        tmr_nxt     = (min_tick_i && tmr_r != 16'hffff) ? tmr_r + 16'h1 : tmr_r;
        rate_dn_nxt = rate_dn_r;
        rate_up_nxt = rate_up_r;
        inst_nxt    = cur_valid_i ? cur_sample_i : inst_r;                  // R10 R9
        mean_nxt    = cur_valid_i ? 16'($signed(mean_r) + (diff >>> AVG_SH)) : mean_r; // R11
        if (dis_nxt != dis_r) begin
            ref_nxt = pct_i;                                                // R5
            tmr_nxt = 16'h0;
        end else if (dis_r && {1'b0, pct_i} + {1'b0, PCT_STEP} <= {1'b0, ref_r}) begin
            rate_dn_nxt = tmr_r / 16'd10;                                   // R4
            ref_nxt     = pct_i;
            tmr_nxt     = 16'h0;
        end else if (!dis_r && !cv_i && {1'b0, pct_i} >= {1'b0, ref_r} + {1'b0, PCT_STEP}) begin
            rate_up_nxt = tmr_r / 16'd10;                                   // R7
            ref_nxt     = pct_i;
            tmr_nxt     = 16'h0;
        end
        tte_nxt = sat16(32'(pct_r) * 32'(rate_dn_r));                       // R3
        if (pct_r >= PCT_FULL) begin
            ttf_nxt = 16'h0;
        end else if (cv_i || pct_r >= CV_PCT) begin
            ttf_nxt = sat16(cv_time(PCT_FULL - pct_r, rate_up_r));          // R8 R6
        end else begin
            ttf_nxt = sat16(32'(CV_PCT - pct_r) * 32'(rate_up_r)
                            + cv_time(PCT_FULL - CV_PCT, rate_up_r));       // R6 R7
        end
        flags_nxt = wr_go && cmd_r == OFS_FLAGS ? (data_r & FLAGS_WR_MASK) : flags_r; // R19
        // alarm sets after the write so a same-cycle clear loses
        if (cur_valid_i && $signed(cur_sample_i) > OVC_THR) flags_nxt[OVC_BIT] = 1'b1; // R10
        if (cur_valid_i && $signed(cur_sample_i) < OVD_THR) flags_nxt[OVD_BIT] = 1'b1; // R10
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pct_r     <= 7'h00;
            ref_r     <= 7'h00;
            tmr_r     <= 16'h0;
            rate_dn_r <= 16'h0;
            rate_up_r <= 16'h0;
            tte_r     <= 16'h0;
            ttf_r     <= 16'h0;
            inst_r    <= 16'h0;
            mean_r    <= 16'h0;
            flags_r   <= FLAGS_RST;                                         // R1
            // starts as charging so the first enabled edge seeds the learning reference when chg_i is low
            dis_r     <= 1'b0;                                              // R4
            chg_r     <= 1'b0;
        end else if (ce_i) begin
            pct_r     <= pct_nxt;
            ref_r     <= ref_nxt;
            tmr_r     <= tmr_nxt;
            rate_dn_r <= rate_dn_nxt;
            rate_up_r <= rate_up_nxt;
            tte_r     <= tte_nxt;
            ttf_r     <= ttf_nxt;
            inst_r    <= inst_nxt;
            mean_r    <= mean_nxt;
            flags_r   <= flags_nxt;
            dis_r     <= dis_nxt;
            chg_r     <= chg_nxt;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    a_rst_flag_set: assert property ($rose(nrst_i) |-> flags_r[RST_DET_BIT]) // R1
        else $error("reset flag not set after reset");
    a_inst_latest: assert property (ce_i && cur_valid_i |=> inst_r == $past(cur_sample_i)) // R10
        else $error("instant current not latest sample");
    a_rate_kept: assert property (ce_i && chg_r && chg_i |=> rate_dn_r == $past(rate_dn_r)) // R5
        else $error("discharge rate changed while charging");
    a_addr_ack: assert property (scl_fall && st_r == ST_ADDR && bit_r == 4'h7 && sh_r == ADDR_WR
        |=> sda_oe_o && nst_r == ST_CMD) // R13
        else $error("write address not acked");
    a_bad_crc_drop: assert property (scl_fall && st_r == ST_WCRC && bit_r == 4'h7
        && sh_r != crc_r && !cur_valid_i |=> flags_r == $past(flags_r)) // R19
        else $error("bad crc write changed flags");
    a_low_first: assert property (st_r == ST_TX && txi_r == 2'd1 |-> tx_r == data_r[15:8]) // R14
        else $error("high byte not second");
    a_no_rep_ones: assert property (scl_fall && st_r == ST_ADDR && bit_r == 4'h7
        && sh_r == ADDR_RD && !rep_r |=> data_r == NO_REP_DATA) // R16
        else $error("read without repeated start not all ones");
    a_crc_tail: assert property (st_r == ST_TX && txi_r == 2'd2 |-> tx_r == crc_r) // R15
        else $error("check byte differs from running crc");
    c_write_ok: cover property (wr_go);
    c_read_rep: cover property (st_r == ST_TX && rep_r && txi_r == 2'd2);
    c_master_nack: cover property (st_r == ST_TX && nack_r && bit_r == 4'h8);
endmodule : gw_word_port

// ### verif/gw_host_model.sv
// i2c master model standing in for the host processor
module gw_host_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_lo_o,
    output logic      sda_lo_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_lo_o = 1'b0;
        sda_lo_o = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tk
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) begin
            x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
        end
        return x;
    endfunction : crc8
    // wait first so sda never moves in the edge where scl falls
    task automatic start();
        tk(2);
        sda_lo_o <= 1'b0;
        tk(2);
        scl_lo_o <= 1'b0;
        tk(2);
        sda_lo_o <= 1'b1;
        tk(2);
        scl_lo_o <= 1'b1;
    endtask : start
    task automatic stop();
        tk(2);
        sda_lo_o <= 1'b1;
        tk(2);
        scl_lo_o <= 1'b0;
        tk(2);
        sda_lo_o <= 1'b0;
        tk(4);
    endtask : stop
    // sampled mid high phase, away from the device's own edges
    task automatic bit_x(input logic b, output logic r);
        tk(2);
        sda_lo_o <= ~b;
        tk(2);
        scl_lo_o <= 1'b0;
        tk(2);
        @(negedge clk_i);
        r = sda_i;
        tk(2);
        scl_lo_o <= 1'b1;
    endtask : bit_x
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic k);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], b);
            q[i] = b;
        end
        bit_x(a, k);
    endtask : xfer
    task automatic word_rd(input logic [7:0] adr, input logic [7:0] cmd, input logic rep,
                           output logic [15:0] w, output logic [7:0] c,
                           output logic [3:0] k);
        logic [7:0] q;
        logic       n;
        start();
        xfer(adr, 1'b1, q, k[0]);
        xfer(cmd, 1'b1, q, k[1]);
        if (!rep) begin
            stop();
        end
        start();
        xfer(adr | 8'h01, 1'b1, q, k[2]);
        xfer(8'hff, 1'b0, w[7:0], k[3]);
        xfer(8'hff, 1'b0, w[15:8], n);
        xfer(8'hff, 1'b1, c, n);
        stop();
    endtask : word_rd
    task automatic word_wr(input logic [7:0] cmd, input logic [15:0] v, input logic bad,
                           output logic [4:0] k);
        logic [7:0] q;
        logic [7:0] c;
        c = crc8(crc8(crc8(crc8(8'h00, 8'h16), cmd), v[7:0]), v[15:8]);
        start();
        xfer(8'h16, 1'b1, q, k[0]);
        xfer(cmd, 1'b1, q, k[1]);
        xfer(v[7:0], 1'b1, q, k[2]);
        xfer(v[15:8], 1'b1, q, k[3]);
        xfer(c ^ {7'h00, bad}, 1'b1, q, k[4]);
        stop();
    endtask : word_wr
endmodule : gw_host_model

// ### verif/tb_top.sv
// self-checking bench for the gauge host word port
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import gw_pkg::*;
    logic        clk   = 1'b0;
    logic        nrst  = 1'b0;
    logic [6:0]  pct   = 7'h32;
    logic        chg   = 1'b0;
    logic        cv    = 1'b0;
    logic        mtick = 1'b0;
    logic [15:0] cur   = 16'h0000;
    logic        cvld  = 1'b0;
    wire logic   sda_drv, sda_oe, rdet, scl_lo, sda_lo;
    logic [15:0] w, a, b;
    logic [7:0]  c;
    logic [3:0]  k;
    logic [4:0]  kw;
    int          fail_count = 0;
    int          tests_run  = 0;
    // both lines are pulled up; any pulling party wins
    wire logic   scl = ~scl_lo;
    wire logic   sda = ~(sda_lo | sda_oe);
    always #50 clk = ~clk;
    gw_word_port gw_word_port_inst (
        .clk_sys_i(clk), .nrst_i(nrst), .ce_i(1'b1), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_drv), .sda_oe_o(sda_oe), .pct_i(pct), .chg_i(chg), .cv_i(cv),
        .min_tick_i(mtick), .cur_sample_i(cur), .cur_valid_i(cvld),
        .reset_detected_o(rdet)
    );
    gw_host_model gw_host_model_inst (
        .clk_i(clk), .sda_i(sda), .scl_lo_o(scl_lo), .sda_lo_o(sda_lo)
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        gw_host_model_inst.word_rd(8'h16, cmd, 1'b1, w, c, k);
        chk({12'h000, k}, 16'h0000);
        chk(w, exp);
        chk({8'h00, c}, {8'h00, gw_host_model_inst.crc8(gw_host_model_inst.crc8(
            gw_host_model_inst.crc8(gw_host_model_inst.crc8(gw_host_model_inst.crc8(
            8'h00, 8'h16), cmd), 8'h17), exp[7:0]), exp[15:8])});
    endtask : rd
    task automatic wr(input logic [7:0] cmd, input logic [15:0] v, input logic bad);
        gw_host_model_inst.word_wr(cmd, v, bad, kw);
        chk({11'h000, kw}, 16'h0000);
    endtask : wr
    task automatic raw(input logic [7:0] adr, input logic rep);
        gw_host_model_inst.word_rd(adr, OFS_TTF, rep, w, c, k);
    endtask : raw
    task automatic tick_n(input int n);
        repeat (n) begin
            @(posedge clk);
            mtick <= 1'b1;
            @(posedge clk);
            mtick <= 1'b0;
        end
    endtask : tick_n
    task automatic sample(input logic [15:0] s);
        @(posedge clk);
        cur <= s;
        cvld <= 1'b1;
        @(posedge clk);
        cvld <= 1'b0;
    endtask : sample
    // bounded overall run; a hang ends in the same report
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge clk);
        chk({15'h0000, rdet}, 16'h0001);
        chk({15'h0000, sda_drv | sda_oe}, 16'h0000);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rd(OFS_FLAGS, 16'h00c0);
        wr(OFS_FLAGS, 16'h0000, 1'b0);
        chk({15'h0000, rdet}, 16'h0000);
        rd(OFS_FLAGS, 16'h0040);
        wr(OFS_FLAGS, 16'h0080, 1'b1);
        rd(OFS_FLAGS, 16'h0040);
        tick_n(100);
        pct <= 7'h28;
        repeat (4) @(posedge clk);
        rd(OFS_TTE, 16'h0190);
        chg <= 1'b1;
        pct <= 7'h2d;
        rd(OFS_TTE, 16'h01c2);
        tick_n(50);
        pct <= 7'h37;
        repeat (4) @(posedge clk);
        raw(8'h16, 1'b1);
        a = w;
        chk(a, 16'h01b3);
        cv <= 1'b1;
        pct <= 7'h5a;
        raw(8'h16, 1'b1);
        b = w;
        chk({15'h0000, a > b}, 16'h0001);
        pct <= 7'h5f;
        raw(8'h16, 1'b1);
        chk({15'h0000, b > w && w != 16'h0000}, 16'h0001);
        pct <= 7'h62;
        rd(OFS_PCT, 16'h0062);
        gw_host_model_inst.word_rd(8'h16, OFS_PCT, 1'b0, w, c, k);
        chk(w, 16'hffff);
        raw(8'h20, 1'b1);
        chk({15'h0000, k[0]}, 16'h0001);
        rd(8'h40, 16'h0000);
        sample(16'h8fff);
        sample(16'hfc18);
        rd(OFS_FLAGS, 16'h0400);
        rd(OFS_INST, 16'hfc18);
        gw_host_model_inst.word_rd(8'h16, OFS_MEAN, 1'b1, w, c, k);
        chk({15'h0000, w[15] && w != 16'hfc18}, 16'h0001);
        tally_and_finish();
    end
endmodule : tb_top
